// [spl_master.sv]
// Serial peripheral link master: framing, link clock, interrupts and errors.
// Summary of operation
// - Interrupts only for external input or errors.
// - External interrupt forwarded at once, unordered.
// - External interrupt carries source identifier two.
// - Synchronise external interrupt before any use.
// - One interrupt per synchronised rising assertion.
// - Error interrupts only when enabled, identifier one.
// - Block is sole master; 28-bit target window.
// - Free-running link clock, divide four or eight.
// - Start, command, address, data, parity frame.
// - Fields sent most significant bit first.
// - Top command bit: zero write, one read.
// - Low command bits encode 1/2/4/8 bytes.
// - One request outstanding until its response.
// - Outbound line low when idle or waiting.
// - Request parity makes the ones count even.
// - Outbound bit valid three cycles before rise.
// - Sample inbound three cycles after rise.
// - Only aligned sizes, big-endian field order.
// - Timeout returns zero; log only when enabled.
`timescale 1ns/10ps
`include "spl_cfg.svh"
module spl_master #(
  parameter int unsigned TIMEOUT_CYC = `SPL_TMO_CYC
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              div8_sel_i,
  input  wire logic              error_report_enable_i,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic              req_read_i,
  input  wire spl_pkg::spl_size_t req_size_i,
  input  wire logic [27:0]       req_addr_i,
  input  wire logic [63:0]       req_wdata_i,
  output logic                   rsp_valid_o,
  input  wire logic              rsp_ready_i,
  output logic                   rsp_read_o,
  output logic                   rsp_error_o,
  output logic [63:0]            rsp_rdata_o,
  input  wire logic              err_clear_i,
  output logic                   err_parity_o,
  output logic                   err_timeout_o,
  output logic                   irq_valid_o,
  output logic [1:0]             irq_source_o,
  input  wire logic              external_irq_input_n_i,
  output logic                   link_clock_out_o,
  output logic                   outbound_serial_line_o,
  input  wire logic              inbound_serial_line_i
);
  import spl_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  spl_state_t  state_reg;       // Sequencer state.
  spl_state_t  state_next;      // Next sequencer state.
  logic [2:0]  cnt_reg;         // Phase within the link period.
  logic        sck_reg;         // Link clock output.
  logic        mosi_reg;        // Outbound line output.
  logic [96:0] tx_sr_reg;       // Outbound frame, next bit on top.
  logic [6:0]  tx_left_reg;     // Frame bits still to send.
  logic [6:0]  rx_nbits_reg;    // Data bits expected back.
  logic        rx_read_reg;     // Outstanding request is a read.
  logic        rx_started_reg;  // Response start bit seen.
  logic [6:0]  rx_left_reg;     // Data plus parity bits still due.
  logic        rx_par_reg;      // Running response parity.
  logic [63:0] rx_sr_reg;       // Received data.
  logic [31:0] tmo_cnt_reg;     // Cycles spent waiting.
  logic        done_err_reg;    // Error of the finished request.
  logic        miso_s1_reg;     // Inbound synchroniser, stage one.
  logic        miso_s2_reg;     // Inbound synchroniser, stage two.
  logic [1:0]  samp_dly_reg;    // Sample strobe delayed by the sync.
  logic        ext_s1_reg;      // Interrupt synchroniser, stage one.
  logic        ext_s2_reg;      // Interrupt synchroniser, stage two.
  logic        ext_prev_reg;    // Previous synchronised assertion.
  logic        err_pend_reg;    // Error interrupt waiting to go out.
  logic        err_par_reg;     // Logged parity error.
  logic        err_tmo_reg;     // Logged timeout.
  logic        irq_valid_reg;   // Interrupt pulse.
  logic [1:0]  irq_src_reg;     // Interrupt source identifier.
  logic        buf_in_ready;    // Response buffer has room.

  // ****************************************************************
  // Link clock phase decode
  // ****************************************************************
  wire [2:0]  last_pt  = div8_sel_i ? `SPL_LAST8 : `SPL_LAST4;
  wire [2:0]  half_pt  = div8_sel_i ? `SPL_HALF8 : `SPL_HALF4;
  wire [2:0]  cnt_next = (cnt_reg >= last_pt) ? 3'd0 : cnt_reg + 3'd1;
  wire        shift_tk = (cnt_reg == (div8_sel_i ? `SPL_SHIFT8 : `SPL_SHIFT4));
  wire        samp_tk  = (cnt_reg == (div8_sel_i ? `SPL_SAMP8 : `SPL_SAMP4));
  wire        samp_now = samp_dly_reg[1];
  wire        rx_bit   = miso_s2_reg;

  // ****************************************************************
  // Request decode and frame build
  // ****************************************************************
  wire        accept    = (state_reg == ST_IDLE) && req_valid_i;
  wire [2:0]  cmd       = {req_read_i ? `SPL_CMD_READ : `SPL_CMD_WRITE,
                           req_size_i};
  wire [6:0]  nbits     = `SPL_BYTE_BITS << req_size_i;
  wire [6:0]  nbits_tx  = req_read_i ? 7'd0 : nbits;
  wire [2:0]  amask     = 3'(3'b111 >> (2'd3 - req_size_i));
  wire        misalign  = |(req_addr_i[2:0] & amask);
  wire [63:0] wdata_top = req_read_i ? 64'h0000_0000_0000_0000 :
                          (req_wdata_i << (`SPL_DATA_MAX - nbits));
  wire [96:0] frame_raw = {1'b1, cmd, req_addr_i, wdata_top, 1'b0};
  wire        frame_par = ^frame_raw;
  wire [96:0] frame     = frame_raw |
                          ({96'd0, frame_par} << (`SPL_DATA_MAX - nbits_tx));

  // ****************************************************************
  // Response decode
  // ****************************************************************
  wire        rx_last  = (state_reg == ST_RECV) && samp_now && rx_started_reg &&
                         (rx_left_reg == 7'd1);
  wire        par_bad  = rx_last && (rx_par_reg ^ rx_bit);
  wire        tmo_hit  = (state_reg == ST_RECV) && !rx_last &&
                         (tmo_cnt_reg >= TIMEOUT_CYC);
  wire        link_err = par_bad || tmo_hit;
  wire        log_en   = link_err && error_report_enable_i;
  wire        ext_rise = ext_s2_reg && !ext_prev_reg;

  // Response word: read flag, error flag, data.
  wire [65:0] rsp_word = {rx_read_reg, done_err_reg, rx_sr_reg};
  wire        rsp_push = (state_reg == ST_DONE);

  // Request handshake: taken only when nothing is outstanding.
  assign req_ready_o = (state_reg == ST_IDLE);

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = misalign ? ST_DONE : ST_SEND;
        end
      end
      ST_SEND: begin
        if (shift_tk && (tx_left_reg == 7'd0)) begin
          state_next = ST_RECV;
        end
      end
      ST_RECV: begin
        if (rx_last || tmo_hit) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (buf_in_ready) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // ****************************************************************
  // Link clock: free running, never gated by traffic.
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 3'd0;
      sck_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      sck_reg <= (cnt_next >= half_pt);
    end
  end

  // ****************************************************************
  // Synchronisers for the inbound line and the interrupt pin.
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      miso_s1_reg  <= 1'b0;
      miso_s2_reg  <= 1'b0;
      samp_dly_reg <= 2'b00;
      ext_s1_reg   <= 1'b0;
      ext_s2_reg   <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      miso_s1_reg  <= inbound_serial_line_i;
      miso_s2_reg  <= miso_s1_reg;
      samp_dly_reg <= {samp_dly_reg[0], samp_tk};
      ext_s1_reg   <= !external_irq_input_n_i;
      ext_s2_reg   <= ext_s1_reg;
      ext_prev_reg <= ext_s2_reg;
    end
  end

  // ****************************************************************
  // Transmit path: the shift point lies three cycles before a rise.
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg    <= ST_IDLE;
      mosi_reg     <= 1'b0;
      tx_sr_reg    <= '0;
      tx_left_reg  <= 7'd0;
      rx_nbits_reg <= 7'd0;
      rx_read_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        tx_sr_reg    <= frame;
        tx_left_reg  <= `SPL_HDR_BITS + nbits_tx;
        rx_nbits_reg <= req_read_i ? nbits : 7'd0;
        rx_read_reg  <= req_read_i;
      end else if ((state_reg == ST_SEND) && shift_tk) begin
        if (tx_left_reg != 7'd0) begin
          mosi_reg    <= tx_sr_reg[96];
          tx_sr_reg   <= {tx_sr_reg[95:0], 1'b0};
          tx_left_reg <= tx_left_reg - 7'd1;
        end else begin
          mosi_reg <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Receive path: hunt for the start bit, then data and parity.
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rx_started_reg <= 1'b0;
      rx_left_reg    <= 7'd0;
      rx_par_reg     <= 1'b0;
      rx_sr_reg      <= '0;
      tmo_cnt_reg    <= 32'd0;
      done_err_reg   <= 1'b0;
    end else if (accept) begin
      rx_started_reg <= 1'b0;
      rx_sr_reg      <= '0;
      tmo_cnt_reg    <= 32'd0;
      done_err_reg   <= misalign;
    end else if (state_reg == ST_RECV) begin
      tmo_cnt_reg <= tmo_cnt_reg + 32'd1;
      if (tmo_hit) begin
        rx_sr_reg    <= '0;
        done_err_reg <= 1'b1;
      end else if (samp_now && !rx_started_reg) begin
        if (rx_bit) begin
          rx_started_reg <= 1'b1;
          rx_left_reg    <= rx_nbits_reg + 7'd1;
          rx_par_reg     <= 1'b1;
        end
      end else if (samp_now) begin
        rx_par_reg  <= rx_par_reg ^ rx_bit;
        rx_left_reg <= rx_left_reg - 7'd1;
        if (rx_last) begin
          done_err_reg <= par_bad;
        end else begin
          rx_sr_reg <= {rx_sr_reg[62:0], rx_bit};
        end
      end
    end
  end

  // ****************************************************************
  // Error log and interrupts; a new event beats a clear.
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      err_par_reg   <= 1'b0;
      err_tmo_reg   <= 1'b0;
      err_pend_reg  <= 1'b0;
      irq_valid_reg <= 1'b0;
      irq_src_reg   <= 2'd0;
    end else begin
      err_par_reg <= (par_bad && error_report_enable_i) ||
                     (err_par_reg && !err_clear_i);
      err_tmo_reg <= (tmo_hit && error_report_enable_i) ||
                     (err_tmo_reg && !err_clear_i);
      irq_valid_reg <= ext_rise || err_pend_reg || log_en;
      if (ext_rise) begin
        irq_src_reg  <= `SPL_SRC_EXT;
        err_pend_reg <= err_pend_reg || log_en;
      end else if (err_pend_reg || log_en) begin
        irq_src_reg  <= `SPL_SRC_ERR;
        err_pend_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Response buffer: two entries; a stalled consumer holds the sequencer in DONE once both are full.
  // ****************************************************************
  spl_buf2 #(
    .WIDTH (66),
    .DEPTH (2)
  ) u_rsp_buf (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_valid_i  (rsp_push),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (rsp_word),
    .out_valid_o (rsp_valid_o),
    .out_ready_i (rsp_ready_i),
    .out_data_o  ({rsp_read_o, rsp_error_o, rsp_rdata_o})
  );

  // Outputs straight from registers.
  assign link_clock_out_o       = sck_reg;
  assign outbound_serial_line_o = mosi_reg;
  assign err_parity_o           = err_par_reg;
  assign err_timeout_o          = err_tmo_reg;
  assign irq_valid_o            = irq_valid_reg;
  assign irq_source_o           = irq_src_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // After a bit change the link clock is low for two samples, then rises.
  sequence s_setup3;
    ##1 (!sck_reg)[*2] ##1 sck_reg;
  endsequence

  a_idle_line_low: assert property (
    (state_reg == ST_IDLE) |-> !mosi_reg)
    else $error("outbound line high while idle");
  a_single_outstanding: assert property (
    (accept && !misalign) |=> (!req_ready_o)[*8])
    else $error("second request taken while one outstanding");
  a_ext_irq_id: assert property (
    ext_rise |=> irq_valid_o && (irq_source_o == 2'd2))
    else $error("external interrupt missing or wrong source");
  a_err_disabled: assert property (
    (link_err && !error_report_enable_i && !err_clear_i) |=>
      $stable(err_parity_o) && $stable(err_timeout_o))
    else $error("error logged while reporting disabled");
  a_clock_div4: assert property (
    ($rose(sck_reg) && !div8_sel_i && $stable(div8_sel_i)) |->
      ##4 $rose(sck_reg))
    else $error("link clock period not four cycles");
  a_bit_setup: assert property (
    ($changed(mosi_reg) && $stable(div8_sel_i)) |-> s_setup3)
    else $error("outbound bit not set up three cycles early");
  a_frame_parity: assert property (
    accept |=> (^tx_sr_reg == 1'b0) && tx_sr_reg[96])
    else $error("request frame parity odd or no start bit");
  a_timeout_zero: assert property (
    tmo_hit |=> rsp_push && (rsp_word[63:0] == 64'h0000_0000_0000_0000)
      && rsp_word[64])
    else $error("timeout response not zero with error");
  a_irq_only_cause: assert property (
    irq_valid_o |-> $past(ext_rise) || $past(err_pend_reg) || $past(log_en))
    else $error("interrupt without cause");
  a_err_irq_id: assert property (
    (log_en && !ext_rise) |=> irq_valid_o && (irq_source_o == 2'd1))
    else $error("error interrupt missing or wrong source");
endmodule

// [spl_cfg.svh]
// Timing, framing and identifier constants of the serial peripheral link master.
`ifndef SPL_CFG_SVH
`define SPL_CFG_SVH

// ****************************************************************
// Link clock divider points (counter phase within one link period)
// ****************************************************************
`define SPL_LAST4   3'd3
`define SPL_LAST8   3'd7
`define SPL_HALF4   3'd2
`define SPL_HALF8   3'd4
`define SPL_SHIFT4  3'd2
`define SPL_SHIFT8  3'd0
`define SPL_SAMP4   3'd0
`define SPL_SAMP8   3'd6

// ****************************************************************
// Framing
// ****************************************************************
`define SPL_HDR_BITS  7'd33
`define SPL_DATA_MAX  7'd64
`define SPL_BYTE_BITS 7'd8
`define SPL_CMD_READ  1'b1
`define SPL_CMD_WRITE 1'b0

// ****************************************************************
// Interrupt source identifiers
// ****************************************************************
`define SPL_SRC_EXT 2'd2
`define SPL_SRC_ERR 2'd1

// ****************************************************************
// Response timeout
// ****************************************************************
`define SPL_CLK_NS  5
`define SPL_TMO_NS  100000
`define SPL_TMO_CYC (`SPL_TMO_NS / `SPL_CLK_NS)

`endif

// [spl_pkg.sv]
// Types shared by the serial peripheral link master.
package spl_pkg;
  // Request sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEND = 4'b0010,
    ST_RECV = 4'b0100,
    ST_DONE = 4'b1000
  } spl_state_t;

  // Transfer size code: 0 one byte, 1 two, 2 four, 3 eight bytes.
  typedef logic [1:0] spl_size_t;
endpackage

// [spl_buf2.sv]
// Small valid/ready FIFO used on the response path.
`timescale 1ns/10ps
module spl_buf2 #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  import spl_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage entries.
  logic [PW-1:0]    wr_ptr_reg;       // Next entry to fill.
  logic [PW-1:0]    rd_ptr_reg;       // Oldest entry.
  logic [CW-1:0]    count_reg;        // Entries held.
  wire              push;
  wire              pop;

  // Full and empty follow the count exactly.
  assign in_ready_o  = (count_reg != CW'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // ****************************************************************
  // Storage write; entries need no reset as valid gates them.
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // ****************************************************************
  // Pointers and count.
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// [spl_tgt.sv]
// Behavioural link target that decodes request frames and answers them.
`timescale 1ns/10ps
module spl_tgt (
  input  wire logic        sck_i,
  input  wire logic        mosi_i,
  input  wire logic        mute_i,
  input  wire logic        bad_i,
  input  wire logic [63:0] rdata_i,
  output logic             miso_o,
  output logic [2:0]       cmd_o,
  output logic [27:0]      addr_o,
  output logic [63:0]      data_o,
  output logic             par_ok_o,
  output int               frames_o,
  output int               busy_err_o
);
  logic [63:0] v;  // Shift register for incoming fields.
  logic        p;  // Running parity of the current frame.
  int          k;  // Data bit count that the size code asks for.
  // Shifts in n bits, each taken just after a link clock rise.
  task automatic get(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sck_i) #1;
      v = {v[62:0], mosi_i};
      p = p ^ mosi_i;
    end
  endtask
  // Drives one response bit for one whole link period.
  task automatic put(input logic b);
    @(posedge sck_i) #1;
    miso_o = b;
  endtask
  // Acts as a target only: waits for a start bit, decodes, then answers.
  initial begin
    miso_o = 1'b0;
    frames_o = 0;
    busy_err_o = 0;
    forever begin
      v = '0;
      p = 1'b0;
      while (v[0] !== 1'b1) get(1);
      get(3);
      cmd_o = v[2:0];
      get(28);
      addr_o = v[27:0];
      k = 8 << cmd_o[1:0];
      data_o = '0;
      if (cmd_o[2] == 1'b0) begin
        get(k);
        data_o = v & ~(64'hFFFF_FFFF_FFFF_FFFF << k);
      end
      get(1);
      par_ok_o = ~p;
      frames_o++;
      // The master must keep its line low while it waits for us.
      repeat (3) begin
        @(posedge sck_i) #1;
        if (mosi_i !== 1'b0) busy_err_o++;
      end
      if (mute_i == 1'b0) begin
        put(1'b1);
        p = 1'b1;
        for (int i = k - 1; cmd_o[2] && i >= 0; i--) begin
          put(rdata_i[i]);
          p = p ^ rdata_i[i];
        end
        put(p ^ bad_i);
        put(1'b0);
      end
    end
  end
endmodule

// [testbench.sv]
// Self-checking bench for the serial peripheral link master.
`timescale 1ns/10ps
module testbench;
  import spl_pkg::*;
  localparam int unsigned TMO = 600;  // Shortened timeout, above the longest read.
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        div8 = 1'b0;
  logic        en = 1'b1;
  logic        rq_v = 1'b0;
  logic        rq_rd = 1'b0;
  spl_size_t   rq_sz = 2'h0;
  logic [27:0] rq_a = 28'h000_0000;
  logic [63:0] rq_wd = 64'h0123_4567_89AB_CDEF;
  logic [63:0] td = 64'hF0E1_D2C3_B4A5_9687;
  logic        rs_rdy = 1'b1;
  logic        clr = 1'b0;
  logic        ext_n = 1'b1;
  logic        mute = 1'b0;
  logic        bad = 1'b0;
  logic        rq_rdy, rs_v, rs_rd, rs_err, e_par, e_tmo, irq_v, sck, mosi, miso, t_ok;
  logic [63:0] rs_d, t_d;
  logic [1:0]  irq_s;
  logic [2:0]  t_cmd;
  logic [27:0] t_a;
  int          frames, berr, n;
  int          irqs [4] = '{0, 0, 0, 0};
  int          miscompares = 0;
  int          checks_done = 0;
  spl_master #(.TIMEOUT_CYC(TMO)) u_spl_master (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .div8_sel_i(div8), .error_report_enable_i(en), .req_valid_i(rq_v), .req_ready_o(rq_rdy),
    .req_read_i(rq_rd), .req_size_i(rq_sz), .req_addr_i(rq_a), .req_wdata_i(rq_wd),
    .rsp_valid_o(rs_v), .rsp_ready_i(rs_rdy), .rsp_read_o(rs_rd), .rsp_error_o(rs_err),
    .rsp_rdata_o(rs_d), .err_clear_i(clr), .err_parity_o(e_par), .err_timeout_o(e_tmo),
    .irq_valid_o(irq_v), .irq_source_o(irq_s), .external_irq_input_n_i(ext_n),
    .link_clock_out_o(sck), .outbound_serial_line_o(mosi), .inbound_serial_line_i(miso));
  spl_tgt u_spl_tgt (.sck_i(sck), .mosi_i(mosi), .mute_i(mute), .bad_i(bad), .rdata_i(td),
    .miso_o(miso), .cmd_o(t_cmd), .addr_o(t_a), .data_o(t_d), .par_ok_o(t_ok),
    .frames_o(frames), .busy_err_o(berr));
  // Makes the 200 MHz system clock.
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  // Counts interrupt pulses per source identifier.
  always @(posedge clk_sys_i) if (irq_v === 1'b1) irqs[irq_s]++;
  task automatic tick();
    @(posedge clk_sys_i) #1;
  endtask
  task automatic chk(input string nm, input logic [64:0] e, input logic [64:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Ends the run as failed when a bounded wait ran out.
  task automatic lim(input int i);
    if (i >= 4000) begin
      miscompares++;
      give_verdict();
    end
  endtask
  function automatic logic [63:0] msk(input int s);
    return ~(64'hFFFF_FFFF_FFFF_FFFF << (8 << s));
  endfunction
  // Holds a request until the edge where ready is seen high.
  task automatic send(input logic r, input int s, input logic [27:0] a);
    int i;
    rq_rd = r;
    rq_sz = s[1:0];
    rq_a = a;
    rq_v = 1'b1;
    for (i = 0; i < 4000 && rq_rdy !== 1'b1; i++) tick();
    lim(i);
    tick();
    rq_v = 1'b0;
  endtask
  task automatic xfer(input logic r, input int s, input logic [27:0] a);
    int i;
    send(r, s, a);
    for (i = 0; i < 4000 && rs_v !== 1'b1; i++) tick();
    lim(i);
  endtask
  task automatic do_reset(input logic d);
    rst_i = 1'b1;
    div8 = d;
    repeat (20) tick();
    chk("rst_ready", 1, rq_rdy);
    chk("rst_line", 0, mosi);
    chk("rst_valid", 0, rs_v);
    rst_i = 1'b0;
  endtask
  // Measures the link clock period in system cycles.
  task automatic t_clk(input int per);
    int c = 0;
    int k = 0;
    logic o = sck;
    for (int i = 0; i < 40; i++) begin
      tick();
      c++;
      if (sck === 1'b1 && o === 1'b0) begin
        if (k > 0) chk("sck_period", per, c);
        k++;
        c = 0;
      end
      o = sck;
    end
    chk("sck_runs", 1, k > 2);
  endtask
  task automatic t_wr();
    for (int s = 0; s < 4; s++) begin
      xfer(1'b0, s, 28'hABC_DE00);
      chk("w_err", 0, rs_err);
      chk("w_cmd", {1'b0, s[1:0]}, t_cmd);
      chk("w_addr", 28'hABC_DE00, t_a);
      chk("w_data", rq_wd & msk(s), t_d);
      chk("w_par", 1, t_ok);
      tick();
    end
  endtask
  task automatic t_rd();
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, s, 28'h123_4560);
      chk("r_cmd", {1'b1, s[1:0]}, t_cmd);
      chk("r_data", td & msk(s), rs_d);
      chk("r_flags", 2'h2, {rs_rd, rs_err});
      tick();
    end
  endtask
  task automatic t_par();
    n = irqs[1];
    bad = 1'b1;
    xfer(1'b1, 0, 28'h000_0010);
    chk("p_err", 1, rs_err);
    repeat (3) tick();
    chk("p_log", 1, e_par);
    chk("p_irq", n + 1, irqs[1]);
    clr = 1'b1;
    tick();
    clr = 1'b0;
    en = 1'b0;
    xfer(1'b0, 0, 28'h000_0010);
    chk("p_err_off", 1, rs_err);
    repeat (3) tick();
    chk("p_log_off", 0, e_par);
    chk("p_irq_off", n + 1, irqs[1]);
    en = 1'b1;
    bad = 1'b0;
  endtask
  task automatic t_tmo();
    n = irqs[1];
    mute = 1'b1;
    xfer(1'b1, 3, 28'h000_0008);
    chk("t_resp", 65'h1_0000_0000_0000_0000, {rs_err, rs_d});
    repeat (3) tick();
    chk("t_log", 1, e_tmo);
    chk("t_irq", n + 1, irqs[1]);
    mute = 1'b0;
    clr = 1'b1;
    tick();
    clr = 1'b0;
  endtask
  // A misaligned request is answered locally, with no frame on the line.
  task automatic t_mis();
    n = frames;
    xfer(1'b0, 2, 28'h000_0006);
    chk("m_resp", 65'h1_0000_0000_0000_0000, {rs_err, rs_d});
    repeat (20) tick();
    chk("m_frames", n, frames);
    chk("m_logs", 0, {e_par, e_tmo});
  endtask
  // Two answers are parked while the consumer stalls, then drained in order.
  task automatic t_buf();
    rs_rdy = 1'b0;
    send(1'b0, 1, 28'h000_0020);
    send(1'b1, 1, 28'h000_0021);
    repeat (3) tick();
    chk("b_head", 2'h2, {rs_v, rs_err});
    rs_rdy = 1'b1;
    tick();
    chk("b_next", 2'h3, {rs_v, rs_err});
    tick();
    chk("b_empty", 0, rs_v);
  endtask
  task automatic t_ext();
    n = irqs[2];
    send(1'b0, 3, 28'h000_0040);
    ext_n = 1'b0;
    repeat (5) tick();
    ext_n = 1'b1;
    repeat (6) tick();
    chk("x_inflight", {n + 1, 1'b0}, {irqs[2], rq_rdy});
    xfer(1'b1, 0, 28'h000_0041);
    tick();
    ext_n = 1'b0;
    repeat (30) tick();
    ext_n = 1'b1;
    repeat (10) tick();
    chk("x_edges", n + 2, irqs[2]);
    chk("x_other", 0, irqs[0] + irqs[3]);
  endtask
  initial begin
    do_reset(1'b0);
    t_clk(4);
    t_wr();
    t_rd();
    t_par();
    t_tmo();
    t_mis();
    t_buf();
    t_ext();
    do_reset(1'b1);
    t_clk(8);
    t_wr();
    chk("busy_line", 0, berr);
    give_verdict();
  end
endmodule
